// [shared/eti_pkg.sv]
// constants, offsets and fixed-channel tables of the event/task interconnect
// assumes a 32-bit APB slave with a 12-bit byte address
package eti_pkg;
   localparam int NCH   = 32;
   localparam int NPROG = 20;
   localparam int NGRP  = 6;
   localparam int NEV   = 32;
   localparam int NTK   = 32;
   localparam int NGT   = 2 * NGRP;
   localparam int NFIX  = NCH - NPROG;

   typedef logic [31:0] eti_addr_t;

   // own base: group tasks sit at base + 8g (enable) and + 8g + 4 (disable)
   localparam eti_addr_t ETI_BASE = 32'h4001_F000;
   // event i answers at EVT_BASE + 4i, task j at TSK_BASE + 4j
   localparam eti_addr_t EVT_BASE = 32'h4000_0100;
   localparam eti_addr_t TSK_BASE = 32'h4000_0000;

   localparam logic [11:0] OFF_GRP_TASK = 12'h000;
   localparam logic [11:0] OFF_CH_EN     = 12'h500;
   localparam logic [11:0] OFF_CH_EN_SET = 12'h504;
   localparam logic [11:0] OFF_CH_EN_CLR = 12'h508;
   localparam logic [11:0] OFF_EP        = 12'h510;
   localparam logic [11:0] OFF_EP_END    = 12'h5B0;
   localparam logic [11:0] OFF_GROUP     = 12'h800;
   localparam logic [11:0] OFF_GROUP_END = 12'h818;
   localparam logic [11:0] OFF_FORK      = 12'h910;
   localparam logic [11:0] OFF_FORK_END  = 12'h990;
   localparam logic [11:0] OFF_GT_END    = 12'h030;

   localparam logic [31:0] CH_EN_RST = 32'h0000_0000;
   localparam eti_addr_t   EP_RST    = 32'h0000_0000;
   localparam logic [31:0] GROUP_RST = 32'h0000_0000;

   // fixed channels 20..31: event and task indices
   // events: 0,1 timer compare0/1; 2 match; 3 ready; 4 address; 5 end; 6 rt compare0
   // tasks: 0 txen; 1 rxen; 2 radio off; 3 resolver start; 4 keystream; 5 crypt;
   //        6,7 timer capture1/2; 8 timer clear; 9 timer start
   localparam logic [4:0] FIX_EVT [NFIX] = '{5'h00, 5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
                                             5'h04, 5'h05, 5'h06, 5'h06, 5'h06, 5'h06};
   localparam logic [4:0] FIX_TSK [NFIX] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                             5'h06, 5'h07, 5'h00, 5'h01, 5'h08, 5'h09};
endpackage

// [shared/eti_cfg_if.sv]
// channel configuration and routing results between register file and router
// assumes both ends on the same clock; the router side is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface eti_cfg_if;
   import eti_pkg::*;
   logic [NCH-1:0]  ch_en;
   eti_addr_t       ev_ep   [NCH];
   eti_addr_t       tk_ep   [NCH];
   eti_addr_t       fork_ep [NCH];
   logic [NEV-1:0]  evt;
   logic [NTK-1:0]  task_d;
   logic [NGRP-1:0] gen;
   logic [NGRP-1:0] gdis;
   modport regs (output ch_en, ev_ep, tk_ep, fork_ep, evt, input task_d, gen, gdis);
   modport rt   (input ch_en, ev_ep, tk_ep, fork_ep, evt, output task_d, gen, gdis);
endinterface
`default_nettype wire

// [rtl/eti_router.sv]
// per-channel event match and task fan-out, combinational
// assumes events are one-cycle pulses on the interconnect clock
`timescale 1ns/1ps
`default_nettype none
module eti_router (
   eti_cfg_if.rt rif
);
   import eti_pkg::*;

   // one-hot over peripheral tasks then group tasks (en/dis interleaved)
   function automatic logic [NTK+NGT-1:0] tgt(input eti_addr_t a);
      logic [NTK+NGT-1:0] r;
      r = '0;
      if (a[1:0] == 2'b00 && a[31:7] == TSK_BASE[31:7])
         r[a[6:2]] = 1'b1;
      else if (a[1:0] == 2'b00 && a[31:6] == ETI_BASE[31:6] && a[5:2] < 4'(NGT))
         r[NTK + int'(a[5:2])] = 1'b1;
      return r;
   endfunction

   logic [NTK+NGT-1:0] sel [NCH];
   logic [NCH-1:0]     hit;

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         wire ev_ok = rif.ev_ep[c][1:0] == 2'b00 &&
                      rif.ev_ep[c][31:7] == EVT_BASE[31:7];
         assign hit[c] = rif.ch_en[c] & ev_ok & rif.evt[rif.ev_ep[c][6:2]];
         assign sel[c] = hit[c] ? (tgt(rif.tk_ep[c]) | tgt(rif.fork_ep[c])) : '0;
      end
   endgenerate

   // several channels may share an event or a task; hits simply merge
   logic [NTK+NGT-1:0] acc;
   always_comb begin
      acc = '0;
      for (int i = 0; i < NCH; i++)
         acc = acc | sel[i];
   end

   assign rif.task_d = acc[NTK-1:0];
   generate
      for (c = 0; c < NGRP; c++) begin : g_grp
         assign rif.gen[c]  = acc[NTK + 2*c];
         assign rif.gdis[c] = acc[NTK + 2*c + 1];
      end
   endgenerate
endmodule
`default_nettype wire

// [rtl/eti_top.sv]
// event/task interconnect: APB register file, channel enables, task outputs
// assumes peripherals give one-cycle event pulses on pclk and take
// one-cycle task pulses; pclk stands in for the interconnect clock
//
// Operation
// - 32 channels, 0-19 programmable, 20-31 fixed
// - each channel: event, task, fork endpoints
// - event on enabled channel fires its task
// - endpoints hold event or task register addresses
// - forwarded signals resynchronised to interconnect clock
// - synchronous event reaches task one period later
// - fork task fires with primary task
// - enable per channel, plus set and clear
// - group enable beats simultaneous group disable
// - group tasks reachable through channel task endpoints
// - events fan out, tasks fan in
// - fixed endpoints read-only, still enable and group
// - fixed channels keep a writable fork endpoint
// - fixed channels wire timer, radio, counter events
// - group task pairs at consecutive word offsets
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eti_top (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [eti_pkg::NEV-1:0] evt_in,
   output logic      [eti_pkg::NTK-1:0] task_out
);
   import eti_pkg::*;

   eti_cfg_if rif ();

   eti_router eti_router_inst (
      .rif (rif)
   );

   logic [NCH-1:0]  ch_en_q;
   logic [NCH-1:0]  ch_en_d;
   eti_addr_t       ep_q   [2*NPROG];
   eti_addr_t       fork_q [NCH];
   logic [NCH-1:0]  grp_q  [NGRP];
   logic [31:0]     prdata_q;
   logic [31:0]     rdata;
   logic            pready_q;
   logic            pslverr_q;
   logic [NTK-1:0]  task_q;

   // bus decode
   wire        setup    = psel & ~penable;
   wire        wr       = psel & penable & pready_q & pwrite;
   wire        aligned  = paddr[1:0] == 2'b00;
   wire        hit_en   = aligned && paddr == OFF_CH_EN;
   wire        hit_set  = aligned && paddr == OFF_CH_EN_SET;
   wire        hit_clr  = aligned && paddr == OFF_CH_EN_CLR;
   wire        hit_gt   = aligned && paddr >= OFF_GRP_TASK && paddr < OFF_GT_END;
   wire        hit_ep   = aligned && paddr >= OFF_EP && paddr < OFF_EP_END;
   wire        hit_grp  = aligned && paddr >= OFF_GROUP && paddr < OFF_GROUP_END;
   wire        hit_fork = aligned && paddr >= OFF_FORK && paddr < OFF_FORK_END;
   wire        mapped   = hit_en | hit_set | hit_clr | hit_gt |
                          hit_ep | hit_grp | hit_fork;
   wire [11:0] ep_off   = paddr - OFF_EP;
   wire [11:0] grp_off  = paddr - OFF_GROUP;
   wire [11:0] fork_off = paddr - OFF_FORK;
   wire [5:0]  ep_idx   = ep_off[7:2];
   wire [2:0]  grp_idx  = grp_off[4:2];
   wire [4:0]  fork_idx = fork_off[6:2];
   wire [3:0]  gt_idx   = paddr[5:2];

   // software-triggered group tasks, same offsets the channels target
   logic [NGRP-1:0] sw_gen;
   logic [NGRP-1:0] sw_gdis;
   logic [NGRP-1:0] all_gen;
   logic [NGRP-1:0] all_gdis;

   genvar g;
   generate
      for (g = 0; g < NGRP; g++) begin : g_gt
         assign sw_gen[g]   = wr & hit_gt & pwdata[0] &
                              (gt_idx == 4'(2*g));
         assign sw_gdis[g]  = wr & hit_gt & pwdata[0] &
                              (gt_idx == 4'(2*g + 1));
         assign all_gen[g]  = sw_gen[g] | rif.gen[g];
         assign all_gdis[g] = sw_gdis[g] | rif.gdis[g];
      end
   endgenerate

   // endpoints seen by the router; fixed ones come from constants
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ep
         if (c < NPROG) begin : g_prog
            assign rif.ev_ep[c] = ep_q[2*c];
            assign rif.tk_ep[c] = ep_q[2*c + 1];
         end else begin : g_fix
            assign rif.ev_ep[c] = EVT_BASE +
                                  {25'h0, FIX_EVT[c-NPROG], 2'b00};
            assign rif.tk_ep[c] = TSK_BASE +
                                  {25'h0, FIX_TSK[c-NPROG], 2'b00};
         end
         assign rif.fork_ep[c] = fork_q[c];
      end
   endgenerate

   assign rif.ch_en = ch_en_q;
   assign rif.evt   = evt_in;

   // enable update: direct writes first, then groups; enable applied last wins
   always_comb begin
      ch_en_d = ch_en_q;
      if (wr && hit_en)
         ch_en_d = pwdata;
      if (wr && hit_set)
         ch_en_d = ch_en_d | pwdata;
      if (wr && hit_clr)
         ch_en_d = ch_en_d & ~pwdata;
      for (int i = 0; i < NGRP; i++)
         if (all_gdis[i])
            ch_en_d = ch_en_d & ~grp_q[i];
      for (int i = 0; i < NGRP; i++)
         if (all_gen[i])
            ch_en_d = ch_en_d | grp_q[i];
   end

   // read mux; group task words and unmapped space read zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_en || hit_set || hit_clr)
         rdata = ch_en_q;
      else if (hit_ep)
         rdata = ep_q[ep_idx];
      else if (hit_grp)
         rdata = grp_q[grp_idx];
      else if (hit_fork)
         rdata = fork_q[fork_idx];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_en_q <= CH_EN_RST;
      end else begin
         ch_en_q <= ch_en_d;
      end
   end

   // only programmable endpoints exist as storage, so fixed ones cannot change
   generate
      for (c = 0; c < 2*NPROG; c++) begin : g_ep_q
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ep_q[c] <= EP_RST;
            end else if (wr && hit_ep && ep_idx == 6'(c)) begin
               ep_q[c] <= pwdata;
            end
         end
      end
      for (c = 0; c < NCH; c++) begin : g_fork_q
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               fork_q[c] <= EP_RST;
            end else if (wr && hit_fork && fork_idx == 5'(c)) begin
               fork_q[c] <= pwdata;
            end
         end
      end
      for (g = 0; g < NGRP; g++) begin : g_grp_q
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               grp_q[g] <= GROUP_RST;
            end else if (wr && hit_grp && grp_idx == 3'(g)) begin
               grp_q[g] <= pwdata;
            end
         end
      end
   endgenerate

   // the single register stage is both resync point and the fixed latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         task_q <= '0;
      end else begin
         task_q <= rif.task_d;
      end
   end

   // zero-wait APB: answer in the access cycle right after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_q <= rdata;
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign task_out = task_q;

endmodule
`default_nettype wire

// [tb/eti_top_checker.sv]
// port assertions for the event/task interconnect
// assumes bind onto eti_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module eti_top_checker (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [eti_pkg::NEV-1:0] evt_in,
   input wire logic [eti_pkg::NTK-1:0] task_out
);
   import eti_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = psel && !penable;
   ready_after_setup_a: assert property (setup |=> pready)
      else $error("pready missing after setup");
   ready_in_access_a: assert property (pready |-> psel && penable && $past(setup))
      else $error("pready outside access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   misaligned_err_a: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access accepted");
   fixed_ep_ro_a: assert property (setup && paddr >= OFF_EP_END && paddr < OFF_GROUP |=> pslverr)
      else $error("fixed endpoint space accepted");
   refused_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   rdata_hold_a: assert property (!(setup && !pwrite) |=> $stable(prdata))
      else $error("prdata moved without read");
   task_cause_a: assert property (evt_in == '0 |=> task_out == '0)
      else $error("task without event");
endmodule
bind eti_top eti_top_checker eti_top_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .evt_in, .task_out);
`default_nettype wire

// [tb/eti_periph.sv]
// peripheral side: raises event pulses, takes task pulses
// assumes events launch just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module eti_periph (
   input  wire logic                    pclk,
   input  wire logic [eti_pkg::NTK-1:0] task_out,
   output logic      [eti_pkg::NEV-1:0] evt_in
);
   initial evt_in = '0;
   // one-cycle pulse on the interconnect clock
   task automatic fire(input logic [31:0] m);
      @(posedge pclk);
      evt_in <= m;
      @(posedge pclk);
      evt_in <= '0;
   endtask
endmodule
`default_nettype wire

// [tb/eti_top_test.sv]
// self-checking bench: APB master, event pulses, task checks
// assumes eti_pkg, eti_periph and the bound checker
`timescale 1ns/1ps
`default_nettype none
module eti_top_test;
   import eti_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, rd, task_out, evt_in;
   logic        pready, pslverr, er;
   int          miscompares = 0;
   int          compares    = 0;
   always #10 pclk = ~pclk;
   eti_top eti_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .evt_in, .task_out);
   eti_periph eti_periph_inst (.pclk, .task_out, .evt_in);
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdr(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // task_out is settled 1 ns after the edge that takes the event
   task automatic ev(input logic [31:0] m);
      eti_periph_inst.fire(m);
      #1;
   endtask
   task automatic t_reset;
      rdr(OFF_CH_EN);
      chk("ch_en rst", rd, CH_EN_RST);
      rdr(OFF_EP);
      chk("ev_ep rst", rd, EP_RST);
      rdr(OFF_CH_EN + 12'h2);
      chk("misaligned", {31'h0, er}, 32'h1);
   endtask
   task automatic t_chan;
      wr(OFF_EP, EVT_BASE + 32'hC);
      wr(OFF_EP + 12'h4, TSK_BASE + 32'h1C);
      wr(OFF_FORK, TSK_BASE + 32'h24);
      wr(OFF_CH_EN_SET, 32'h1);
      rdr(OFF_CH_EN);
      chk("ch_en set", rd, 32'h1);
      ev(32'h8);
      chk("task fire", task_out, 32'h280);
      @(posedge pclk);
      #1 chk("task pulse", task_out, 32'h0);
      wr(OFF_CH_EN_CLR, 32'h1);
      rdr(OFF_CH_EN);
      chk("ch_en clr", rd, 32'h0);
      ev(32'h8);
      chk("task off", task_out, 32'h0);
   endtask
   task automatic t_fixed;
      logic [47:0] fe = 48'h6666_5443_2100;
      logic [47:0] ft = 48'h9810_7654_3210;
      for (int i = 0; i < 12; i++) begin
         wr(OFF_CH_EN, 32'h1 << (20 + i));
         ev(32'h1 << fe[4*i +: 4]);
         chk("fixed", task_out, 32'h1 << ft[4*i +: 4]);
      end
      wr(OFF_FORK + 12'h50, TSK_BASE + 32'h50);
      wr(OFF_CH_EN, 32'h0030_0000);
      ev(32'h1);
      chk("fan out", task_out, 32'h0010_0003);
      wr(OFF_EP_END, 32'h0);
      chk("fixed ro", {31'h0, er}, 32'h1);
   endtask
   task automatic t_group;
      wr(OFF_GROUP, 32'h8);
      wr(OFF_EP + 12'h10, EVT_BASE + 32'h28);
      wr(OFF_EP + 12'h14, ETI_BASE);
      wr(OFF_FORK + 12'h8, ETI_BASE + 32'h4);
      wr(OFF_CH_EN, 32'h4);
      ev(32'h400);
      chk("grp task", task_out, 32'h0);
      rdr(OFF_CH_EN);
      chk("grp en wins", rd, 32'hC);
      wr(OFF_GRP_TASK + 12'h4, 32'h1);
      rdr(OFF_CH_EN);
      chk("grp dis", rd, 32'h4);
      wr(OFF_GROUP + 12'h4, 32'h8);
      wr(OFF_GRP_TASK + 12'h8, 32'h1);
      rdr(OFF_CH_EN);
      chk("grp1 en", rd, 32'hC);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_chan();
      t_fixed();
      t_group();
      close_out();
   end
   // run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      close_out();
   end
endmodule
`default_nettype wire
